// ---- eic_defines.svh ----
`ifndef EIC_DEFINES_SVH
`define EIC_DEFINES_SVH

// register map
`define EIC_CTRL_ADDR      6'h37
`define EIC_CTRL_RESET     8'h00

// latch index of each source inside the five-bit vectors
`define EIC_SRC0           0
`define EIC_SRC1           1
`define EIC_SRC3           2
`define EIC_SRC4           3
`define EIC_SRC5           4
`define EIC_NSRC           5

// filter windows in high_freq_clock periods (reject below, accept from)
`define EIC_S05_REJ_FC     2
`define EIC_S05_ACC_FC     7
`define EIC_S34_REJ_FC     7
`define EIC_S34_ACC_FC     25
`define EIC_S1F_REJ_FC     15
`define EIC_S1F_ACC_FC     49
`define EIC_S1S_REJ_FC     63
`define EIC_S1S_ACC_FC     193
// slow and sleep modes, in low_freq_clock periods (3.5 kept as 7 halves)
`define EIC_SLOW_REJ_FS    1
`define EIC_SLOW_ACC_FS2   7
// latest time for a new source-one filter select to bite, fc periods
`define EIC_S1_SWITCH_FC   64

// stable-sample count that flips a filter: midpoint of the window
`define EIC_MID(rej, acc)  8'(((rej) + (acc)) / 2)
`define EIC_SLOW_MID       8'(((2 * `EIC_SLOW_REJ_FS) + `EIC_SLOW_ACC_FS2) / 4)

`endif

// ---- eic_pkg.sv ----
package eic_pkg;

    // trigger choice for sources three and four
    typedef enum logic [1:0] {
        EIC_TRIG_RISE,
        EIC_TRIG_FALL,
        EIC_TRIG_BOTH,
        EIC_TRIG_HIGH
    } eic_trig_e;

    // control register laid out msb first as it sits on the data bus
    typedef struct packed {
        logic      source1_filter_select;
        logic      source0_pin_function;
        eic_trig_e source3_trigger_select;
        eic_trig_e source4_trigger_select;
        logic      source1_edge_select;
        logic      spare;
    } eic_ctrl_s;

    // enable inputs coming from the core
    typedef struct packed {
        logic master_irq_enable;
        logic source0_enable_flag;
        logic source1_enable_flag;
        logic source3_enable_flag;
        logic source4_enable_flag;
        logic source5_enable_flag;
        logic source3_latch_condition;
    } eic_enable_s;

    // sfr access from the core
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } eic_sfr_req_s;

endpackage : eic_pkg

// ---- eic_noise_filter.sv ----
`timescale 1ns/1ps
`include "eic_defines.svh"

module eic_noise_filter (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       pin_sync,
    input  wire logic       sample_en,
    input  wire logic [7:0] threshold,
    output logic            level_ff,
    output logic            rise_ff,
    output logic            fall_ff
);
    import eic_pkg::*;

    logic [7:0] cnt_ff;
    logic       init_ff;
    logic       flip;

    // a differing level must survive threshold samples in a row
    assign flip = sample_en && (pin_sync != level_ff) && ((cnt_ff + 8'h01) >= threshold);

    // run length of the level that differs from the accepted one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 8'h00;
        end else if (sample_en) begin
            if (pin_sync == level_ff || flip) begin
                cnt_ff <= 8'h00; // glitch shorter than the window is dropped
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // first accepted level after reset is adopted silently, so a pin that
    // already sits high at release gives no edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            level_ff <= 1'b0;
            init_ff  <= 1'b0;
            rise_ff  <= 1'b0;
            fall_ff  <= 1'b0;
        end else begin
            rise_ff <= flip && init_ff && pin_sync;
            fall_ff <= flip && init_ff && !pin_sync;
            if (flip) begin
                level_ff <= pin_sync;
            end
            if (sample_en && ((pin_sync == level_ff) || flip)) begin
                init_ff <= 1'b1;
            end
        end
    end

endmodule // eic_noise_filter

// ---- eic_top.sv ----
`timescale 1ns/1ps
`include "eic_defines.svh"


module eic_top (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire eic_pkg::eic_sfr_req_s sfr_req,
    output logic [7:0]                 sfr_rdata_ff,
    input  wire logic                  slow_mode,
    input  wire logic                  fs_tick,
    input  wire logic                  ext_irq_source0,
    input  wire logic                  ext_irq_source1,
    input  wire logic                  ext_irq_source3,
    input  wire logic                  ext_irq_source4,
    input  wire logic                  ext_irq_source5,
    input  wire eic_pkg::eic_enable_s  enables,
    input  wire logic [4:0]            latch_clear,
    output logic [4:0]                 irq_latch_ff,
    output logic [4:0]                 irq_request_ff,
    output logic                       shared_port_is_irq_ff
);
    import eic_pkg::*;

    eic_ctrl_s  ctrl_ff;
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_sync_ff;
    logic [4:0] pins;
    logic [4:0] lvl;
    logic [4:0] rise;
    logic [4:0] fall;
    logic [4:0] nxt_set;
    logic [1:0] seen_rise_ff;
    logic       sample_en;
    logic [1:0] sync_ok_ff;
    logic [1:0] armed;
    logic [7:0] thr [`EIC_NSRC];

    // filter threshold for the selected source-one window
    function automatic logic [7:0] s1_threshold(input logic fast);
        s1_threshold = fast ? `EIC_MID(`EIC_S1F_REJ_FC, `EIC_S1F_ACC_FC)
                            : `EIC_MID(`EIC_S1S_REJ_FC, `EIC_S1S_ACC_FC);
    endfunction

    // set decision for a source with a two-bit trigger choice
    function automatic logic trig_hit(input eic_trig_e mode, input logic r, input logic f,
                                      input logic l, input logic armed);
        unique case (mode)
            EIC_TRIG_RISE: trig_hit = r;
            EIC_TRIG_FALL: trig_hit = f;
            EIC_TRIG_BOTH: trig_hit = r || f;
            EIC_TRIG_HIGH: trig_hit = l && armed;
        endcase
    endfunction

    assign pins = {ext_irq_source5, ext_irq_source4, ext_irq_source3,
                   ext_irq_source1, ext_irq_source0};

    // two-flop synchroniser; only the second stage feeds the filters
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_ff <= 5'h00;
            pin_sync_ff <= 5'h00;
        end else begin
            pin_meta_ff <= pins;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // the synchroniser leaves reset at zero whatever the pins show, so the
    // filters wait until both stages hold real pin samples; otherwise a pin
    // sitting high at release would look like a fresh rising edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_ok_ff <= 2'b00;
        end else begin
            sync_ok_ff <= {sync_ok_ff[0], 1'b1};
        end
    end

    // sfr write path; software should mask interrupts around this write
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= eic_ctrl_s'(`EIC_CTRL_RESET);
        end else if (sfr_req.wr && sfr_req.addr == `EIC_CTRL_ADDR) begin
            ctrl_ff <= eic_ctrl_s'(sfr_req.wdata);
        end
    end

    // sfr read path; other addresses belong to other blocks and read zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sfr_req.rd && sfr_req.addr == `EIC_CTRL_ADDR) begin
            sfr_rdata_ff <= ctrl_ff;
        end else begin
            sfr_rdata_ff <= 8'h00;
        end
    end

    // pin role mirrored out to the port logic
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shared_port_is_irq_ff <= 1'b0;
        end else begin
            shared_port_is_irq_ff <= ctrl_ff.source0_pin_function;
        end
    end

    // fc samples every cycle; in slow/sleep only once per fs period;
    // nothing is sampled until the synchroniser is primed after reset,
    // which costs two cycles of blindness right after release
    assign sample_en = sync_ok_ff[1] && (slow_mode ? fs_tick : 1'b1);

    // thresholds take the new select the next cycle, well inside 64 fc
    always_comb begin
        for (int i = 0; i < `EIC_NSRC; i++) begin
            thr[i] = `EIC_SLOW_MID;
        end
        if (!slow_mode) begin
            thr[`EIC_SRC0] = `EIC_MID(`EIC_S05_REJ_FC, `EIC_S05_ACC_FC);
            thr[`EIC_SRC5] = `EIC_MID(`EIC_S05_REJ_FC, `EIC_S05_ACC_FC);
            thr[`EIC_SRC1] = s1_threshold(ctrl_ff.source1_filter_select);
            thr[`EIC_SRC3] = `EIC_MID(`EIC_S34_REJ_FC, `EIC_S34_ACC_FC);
            thr[`EIC_SRC4] = `EIC_MID(`EIC_S34_REJ_FC, `EIC_S34_ACC_FC);
        end
    end

    // one filter per pin, ahead of every edge or level decision
    genvar g;
    generate
        for (g = 0; g < `EIC_NSRC; g++) begin : gen_filt
            eic_noise_filter u_filt (
                .sys_clk   (sys_clk),
                .nrst      (nrst),
                .pin_sync  (pin_sync_ff[g]),
                .sample_en (sample_en),
                .threshold (thr[g]),
                .level_ff  (lvl[g]),
                .rise_ff   (rise[g]),
                .fall_ff   (fall[g])
            );
        end
    endgenerate

    // high-level trigger stays disarmed until a filtered rising edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seen_rise_ff <= 2'b00;
        end else begin
            seen_rise_ff <= seen_rise_ff | {rise[`EIC_SRC4], rise[`EIC_SRC3]};
        end
    end

    // a rise seen this cycle arms at once, so the high-level mode answers
    // with the same latency as the edge modes
    assign armed = seen_rise_ff | {rise[`EIC_SRC4], rise[`EIC_SRC3]};

    // latch set conditions per source
    always_comb begin
        nxt_set = 5'h00;
        nxt_set[`EIC_SRC0] = fall[`EIC_SRC0] && ctrl_ff.source0_pin_function;
        nxt_set[`EIC_SRC1] = ctrl_ff.source1_edge_select ? fall[`EIC_SRC1]
                                                         : rise[`EIC_SRC1];
        nxt_set[`EIC_SRC3] = trig_hit(ctrl_ff.source3_trigger_select, rise[`EIC_SRC3],
                                      fall[`EIC_SRC3], lvl[`EIC_SRC3],
                                      armed[0]);
        nxt_set[`EIC_SRC4] = trig_hit(ctrl_ff.source4_trigger_select, rise[`EIC_SRC4],
                                      fall[`EIC_SRC4], lvl[`EIC_SRC4],
                                      armed[1]);
        nxt_set[`EIC_SRC5] = fall[`EIC_SRC5];
    end

    // latches: a set in the same cycle as the core's clear wins, so no
    // edge is lost; pin glitches from output use cannot set source zero
    // a clean edge lands here two sync cycles plus the filter window plus
    // one register stage after the pin moved, well inside the bound
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_latch_ff <= 5'h00;
        end else begin
            irq_latch_ff <= (irq_latch_ff & ~latch_clear) | nxt_set;
        end
    end

    // request gating toward the acceptance logic
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_request_ff <= 5'h00;
        end else begin
            irq_request_ff[`EIC_SRC0] <= enables.master_irq_enable
                && enables.source0_enable_flag && ctrl_ff.source0_pin_function
                && irq_latch_ff[`EIC_SRC0];
            irq_request_ff[`EIC_SRC1] <= enables.master_irq_enable
                && enables.source1_enable_flag && irq_latch_ff[`EIC_SRC1];
            irq_request_ff[`EIC_SRC3] <= enables.master_irq_enable
                && enables.source3_enable_flag && enables.source3_latch_condition
                && irq_latch_ff[`EIC_SRC3];
            irq_request_ff[`EIC_SRC4] <= enables.master_irq_enable
                && enables.source4_enable_flag && irq_latch_ff[`EIC_SRC4];
            irq_request_ff[`EIC_SRC5] <= enables.master_irq_enable
                && enables.source5_enable_flag && irq_latch_ff[`EIC_SRC5];
        end
    end

endmodule // eic_top

// ---- eic_top_props.sv ----
`timescale 1ns/1ps
module eic_top_props (
    input wire logic                  sys_clk,
    input wire logic                  nrst,
    input wire eic_pkg::eic_sfr_req_s sfr_req,
    input wire logic [7:0]            sfr_rdata_ff,
    input wire logic                  slow_mode,
    input wire logic                  ext_irq_source5,
    input wire eic_pkg::eic_enable_s  enables,
    input wire logic [4:0]            latch_clear,
    input wire logic [4:0]            irq_latch_ff,
    input wire logic [4:0]            irq_request_ff,
    input wire logic                  shared_port_is_irq_ff
);
    import eic_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // control byte access: role copy, read data and its idle value
    a_role_copy: assert property (sfr_req.wr && sfr_req.addr == 6'h37
        |-> ##2 shared_port_is_irq_ff == $past(sfr_req.wdata[6], 2)) else $error("role copy");
    a_rd_idle: assert property (!(sfr_req.rd && sfr_req.addr == 6'h37)
        |=> sfr_rdata_ff == 8'h00) else $error("read data not idle");
    a_rd_role: assert property (sfr_req.rd && sfr_req.addr == 6'h37
        |=> sfr_rdata_ff[6] == shared_port_is_irq_ff) else $error("read data bit 6");
    // latch side: port-pin gating, filtered fall, stickiness
    a_src0_gate: assert property ($rose(irq_latch_ff[0]) |-> shared_port_is_irq_ff)
        else $error("source zero set as port pin");
    a_src5_filter: assert property ($rose(irq_latch_ff[4]) && !slow_mode
        |-> !$past(ext_irq_source5, 4)) else $error("source five set without low pin");
    a_latch_hold: assert property (1'b1
        |=> (~irq_latch_ff & $past(irq_latch_ff) & ~$past(latch_clear)) == 5'h00)
        else $error("latch dropped without clear");
    // requests follow latch and enables one edge later
    a_req_src1: assert property (1'b1 |=> irq_request_ff[1] == $past(irq_latch_ff[1]
        & enables.master_irq_enable & enables.source1_enable_flag)) else $error("req one");
    a_req_src3: assert property (1'b1 |=> irq_request_ff[2] == $past(irq_latch_ff[2]
        & enables.master_irq_enable & enables.source3_enable_flag
        & enables.source3_latch_condition)) else $error("req three");
    a_req_src5: assert property (1'b1 |=> irq_request_ff[4] == $past(irq_latch_ff[4]
        & enables.master_irq_enable & enables.source5_enable_flag)) else $error("req five");
    a_req_src0: assert property (1'b1 |=> irq_request_ff[0] == ($past(irq_latch_ff[0]
        & enables.master_irq_enable & enables.source0_enable_flag) & shared_port_is_irq_ff))
        else $error("req zero");
    a_req_src4: assert property (1'b1 |=> irq_request_ff[3] == $past(irq_latch_ff[3]
        & enables.master_irq_enable & enables.source4_enable_flag)) else $error("req four");
endmodule // eic_top_props

bind eic_top eic_top_props i_props (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req),
    .sfr_rdata_ff(sfr_rdata_ff), .slow_mode(slow_mode), .ext_irq_source5(ext_irq_source5),
    .enables(enables), .latch_clear(latch_clear), .irq_latch_ff(irq_latch_ff),
    .irq_request_ff(irq_request_ff), .shared_port_is_irq_ff(shared_port_is_irq_ff));

// ---- eic_pin_src.sv ----
`timescale 1ns/1ps
// external sources on the five pins; idle high keeps falling-edge sources quiet
module eic_pin_src (
    input wire logic   sys_clk,
    output logic [4:0] pin
);
    initial pin = 5'h1f;
    // glitch of w cycles when w is above zero, else a lasting step
    task automatic drive(input int idx, input logic lvl, input int w);
        pin[idx] <= lvl;
        if (w > 0) begin
            repeat (w) @(posedge sys_clk);
            pin[idx] <= ~lvl;
        end
    endtask
endmodule // eic_pin_src

// ---- external_interrupt_conditioner_bench.sv ----
`timescale 1ns/1ps
`include "eic_defines.svh"
module external_interrupt_conditioner_bench;
    import eic_pkg::*;
    logic         sys_clk = 1'b0;
    logic         nrst = 1'b0;
    logic         slow_mode = 1'b0;
    logic         fs_tick = 1'b0;
    logic [2:0]   fs_cnt = 3'h0;
    logic [4:0]   latch_clear = 5'h00;
    logic [4:0]   pin, irq_latch_ff, irq_request_ff;
    logic [7:0]   sfr_rdata_ff, r;
    logic [7:0]   ctrl_m = 8'h00;
    logic         shared_port_is_irq_ff;
    eic_sfr_req_s sfr_req = '0;
    eic_enable_s  enables = '0;
    int           n_fail = 0;
    int           checks_done = 0;

    always #4 sys_clk = ~sys_clk;
    // free-running tick at an eighth of the clock stands for the slow clock
    always @(posedge sys_clk) begin
        fs_cnt  <= fs_cnt + 3'h1;
        fs_tick <= (fs_cnt == 3'h7);
    end

    eic_pin_src i_src (.sys_clk(sys_clk), .pin(pin));
    eic_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req),
        .sfr_rdata_ff(sfr_rdata_ff), .slow_mode(slow_mode), .fs_tick(fs_tick),
        .ext_irq_source0(pin[0]), .ext_irq_source1(pin[1]), .ext_irq_source3(pin[2]),
        .ext_irq_source4(pin[3]), .ext_irq_source5(pin[4]), .enables(enables),
        .latch_clear(latch_clear), .irq_latch_ff(irq_latch_ff),
        .irq_request_ff(irq_request_ff), .shared_port_is_irq_ff(shared_port_is_irq_ff));

    task automatic results();
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_lat(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_fail++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic reset_dut();
        nrst <= 1'b0;
        ctrl_m = 8'h00;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
    endtask
    // enables drop while the byte changes, then the filter select settles
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        enables <= '0;
        @(posedge sys_clk);
        sfr_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        sfr_req <= '0;
        if (a == `EIC_CTRL_ADDR) ctrl_m = d;
        repeat (`EIC_S1_SWITCH_FC + 8) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        sfr_req <= '0;
        #1 chk_byte("rdata", e, sfr_rdata_ff);
        @(posedge sys_clk);
    endtask
    // model: edge or level match for a step to lvl
    function automatic logic expf(input int i, input logic lvl);
        logic [1:0] m;
        m = (i == 2) ? ctrl_m[5:4] : ctrl_m[3:2];
        case (i)
            0: return !lvl && ctrl_m[6];
            4: return !lvl;
            1: return lvl != ctrl_m[1];
            default: return (m == 2'h2) || (lvl == (m != 2'h1));
        endcase
    endfunction
    // model: reject (a=0) or accept (a=1) width in clock periods
    function automatic int win(input int i, input bit a);
        if (i == 0 || i == 4) return a ? `EIC_S05_ACC_FC : `EIC_S05_REJ_FC;
        if (i != 1) return a ? `EIC_S34_ACC_FC : `EIC_S34_REJ_FC;
        if (ctrl_m[7]) return a ? `EIC_S1F_ACC_FC : `EIC_S1F_REJ_FC;
        return a ? `EIC_S1S_ACC_FC : `EIC_S1S_REJ_FC;
    endfunction
    // drive one pin event, watch its latch for a fixed window, then clear it
    task automatic hit(input int i, input logic lvl, input int w, input logic e);
        int n;
        int lat;
        eic_enable_s en;
        logic flag;
        n = (i == 1) ? (ctrl_m[7] ? 32 : 128) : ((i == 2 || i == 3) ? 16 : 4);
        lat = 0;
        en = eic_enable_s'(7'($urandom));
        enables <= en;
        // model of the request gate for this source
        flag = (i == 0) ? (en.source0_enable_flag && ctrl_m[6])
             : (i == 1) ? en.source1_enable_flag
             : (i == 2) ? (en.source3_enable_flag && en.source3_latch_condition)
             : (i == 3) ? en.source4_enable_flag : en.source5_enable_flag;
        flag = flag && en.master_irq_enable && e;
        i_src.drive(i, lvl, w);
        for (int k = 1; k <= 400; k++) begin
            @(posedge sys_clk);
            #1 if (lat == 0 && irq_latch_ff[i] === 1'b1) lat = w + k;
        end
        chk_byte("latch", {7'h0, e}, {7'h0, lat != 0});
        if (e && w == 0 && !slow_mode) chk_lat("latency", n + 3, lat);
        chk_byte("request", {7'h0, flag}, {7'h0, irq_request_ff[i]});
        latch_clear <= 5'h01 << i;
        @(posedge sys_clk);
        latch_clear <= 5'h00;
    endtask

    initial begin
        void'($urandom(32'h68f5));
        reset_dut();
        #1 chk_byte("role", 8'h00, {7'h0, shared_port_is_irq_ff});
        rd(`EIC_CTRL_ADDR, 8'h00);
        r = 8'($urandom);
        wr(`EIC_CTRL_ADDR, r);
        wr(6'h36, ~r);
        rd(`EIC_CTRL_ADDR, r);
        rd(6'h15, 8'h00);
        // as a port pin, source zero ignores clean edges
        wr(`EIC_CTRL_ADDR, 8'h00);
        hit(0, 1'b0, 0, 1'b0);
        hit(0, 1'b1, 0, 1'b0);
        // each filter just under its reject width and at its accept width
        for (int f = 0; f < 2; f++) begin
            wr(`EIC_CTRL_ADDR, 8'h56 | 8'(f << 7));
            for (int i = 0; i < 5; i++) begin
                hit(i, 1'b0, win(i, 0) - 1, 1'b0);
                hit(i, 1'b0, win(i, 1), 1'b1);
            end
        end
        // edge choices; the high level is left for after the second reset
        for (int m = 0; m < 3; m++) begin
            wr(`EIC_CTRL_ADDR, 8'h40 | 8'(m << 4) | 8'(m << 2) | 8'((m << 1) & 2));
            for (int i = 0; i < 5; i++) begin
                hit(i, 1'b0, 0, expf(i, 1'b0));
                hit(i, 1'b1, 0, expf(i, 1'b1));
            end
        end
        slow_mode <= 1'b1;
        hit(4, 1'b0, 7, 1'b0);
        hit(4, 1'b0, 28, 1'b1);
        slow_mode <= 1'b0;
        // pins high through reset: high level needs a fresh rise
        reset_dut();
        wr(`EIC_CTRL_ADDR, 8'h7c);
        #1 chk_byte("latch", 8'h00, {3'h0, irq_latch_ff});
        @(posedge sys_clk);
        hit(3, 1'b0, 0, 1'b0);
        hit(3, 1'b1, 0, 1'b1);
        results();
    end
endmodule // external_interrupt_conditioner_bench
